// [verilog/mbos_slave.sv]
// Modbus output slave: coil and register writes, exception status
// ----------------------------------------------------------------
// Functional notes
// R1: Coil write accepted at addresses 0..15
// R2: Value FF00 switches addressed output on
// R3: Value 0000 off; other outputs unchanged
// R4: Write replies echo request byte-for-byte
// R5: Register preset only at address zero
// R6: Preset bit n drives output n
// R7: Status reply: code 07 plus one byte
// R8: Status LSB is output 0, MSB output 7
// R9: Status carries only outputs 0..7
// R10: Exception reply: code plus 80, code 01/02
// R11: Master latches response and exception codes
// R12: Master stores function-7 byte to destination
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module mbos_slave
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        req_valid_i,
	input  wire logic [7:0]  req_func_i,
	input  wire logic [15:0] req_addr_i,
	input  wire logic [15:0] req_value_i,
	output logic             req_ready_o,
	output logic             tx_valid_o,
	output logic [7:0]       tx_data_o,
	output logic             tx_last_o,
	output logic [15:0]      dout_o,
	input  wire logic        rsp_valid_i,
	input  wire logic [7:0]  rsp_func_i,
	input  wire logic [7:0]  rsp_data_i,
	input  wire logic [7:0]  rsp_dest_i,
	output logic [7:0]       response_function_query_o,
	output logic [7:0]       exception_code_query_o,
	output logic             dest_we_o,
	output logic [7:0]       dest_addr_o,
	output logic [7:0]       dest_data_o
);
	mbos_reply_if rep ();
	logic       start_q;
	logic [7:0] frame_q [5];
	logic [2:0] len_q;

	// Is this a request that may be accepted now
	function automatic logic take(input logic v, input logic b);
		return v && !b;
	endfunction

	// Taken only while ready stands, so a held request is not taken twice
	logic go;
	assign go = take(req_valid_i, rep.busy || start_q || !req_ready_o);

	// ----------------------------------------------------------------
	// Output state
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			dout_o <= mbos_pkg::OUT_RST;
		else if (go)
		begin
			// R1 coil range decode
			if (req_func_i == mbos_pkg::FC_WRITE_COIL &&
			    req_addr_i <= mbos_pkg::COIL_ADDR_MAX)
			begin
				// R2 coil on
				if (req_value_i == mbos_pkg::COIL_ON)
					dout_o[req_addr_i[3:0]] <= 1'b1;
				// R3 coil off, others kept
				else if (req_value_i == mbos_pkg::COIL_OFF)
					dout_o[req_addr_i[3:0]] <= 1'b0;
			end
			// R5 preset at address zero
			else if (req_func_i == mbos_pkg::FC_PRESET_REG &&
			         req_addr_i == mbos_pkg::PRESET_ADDR)
				// R6 whole word to outputs
				dout_o <= req_value_i;
		end
	end

	// ----------------------------------------------------------------
	// Reply frame build
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			start_q <= 1'b0;
			len_q   <= '0;
			for (int i = 0; i < 5; i++)
				frame_q[i] <= mbos_pkg::BYTE_RST;
		end
		else
		begin
			start_q <= go;
			if (go)
			begin
				unique case (req_func_i)
					mbos_pkg::FC_WRITE_COIL, mbos_pkg::FC_PRESET_REG:
					begin
						if ((req_func_i == mbos_pkg::FC_WRITE_COIL &&
						     req_addr_i <= mbos_pkg::COIL_ADDR_MAX &&
						     (req_value_i == mbos_pkg::COIL_ON ||
						      req_value_i == mbos_pkg::COIL_OFF)) ||
						    (req_func_i == mbos_pkg::FC_PRESET_REG &&
						     req_addr_i == mbos_pkg::PRESET_ADDR))
						begin
							// R4 echo of request
							frame_q[0] <= req_func_i;
							frame_q[1] <= req_addr_i[15:8];
							frame_q[2] <= req_addr_i[7:0];
							frame_q[3] <= req_value_i[15:8];
							frame_q[4] <= req_value_i[7:0];
							len_q      <= 3'(mbos_pkg::REQ_BYTES);
						end
						else
						begin
							// R10 illegal address exception
							frame_q[0] <= req_func_i | mbos_pkg::EXC_FLAG;
							frame_q[1] <= mbos_pkg::EXC_ILLEGAL_ADDR;
							len_q      <= 3'(mbos_pkg::EXC_BYTES);
						end
					end
					mbos_pkg::FC_READ_EXC:
					begin
						// R7 code then one byte
						frame_q[0] <= mbos_pkg::FC_READ_EXC;
						// R8 R9 low eight outputs only
						frame_q[1] <= dout_o[7:0];
						len_q      <= 3'(mbos_pkg::STAT_BYTES);
					end
					default:
					begin
						// R10 illegal function exception
						frame_q[0] <= req_func_i | mbos_pkg::EXC_FLAG;
						frame_q[1] <= mbos_pkg::EXC_ILLEGAL_FUNC;
						len_q      <= 3'(mbos_pkg::EXC_BYTES);
					end
				endcase
			end
		end
	end

	assign rep.start = start_q;
	assign rep.frame = frame_q;
	assign rep.len   = len_q;

	// Ready shown one cycle late from the busy state
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			req_ready_o <= 1'b0;
		else
			req_ready_o <= !(rep.busy || start_q || go);
	end

	mbos_reply_tx u_tx
	(
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.rep        (rep),
		.tx_valid_o (tx_valid_o),
		.tx_data_o  (tx_data_o),
		.tx_last_o  (tx_last_o)
	);

	// ----------------------------------------------------------------
	// Master-side response capture
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			response_function_query_o <= mbos_pkg::BYTE_RST;
			exception_code_query_o    <= mbos_pkg::BYTE_RST;
		end
		else if (rsp_valid_i)
		begin
			// R11 latch function and exception code
			response_function_query_o <= rsp_func_i;
			if (rsp_func_i[7])
				exception_code_query_o <= rsp_data_i;
		end
	end

	// Function-7 data into destination array
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			dest_we_o   <= 1'b0;
			dest_addr_o <= mbos_pkg::BYTE_RST;
			dest_data_o <= mbos_pkg::BYTE_RST;
		end
		else
		begin
			// R12 store status byte
			dest_we_o <= rsp_valid_i && rsp_func_i == mbos_pkg::FC_READ_EXC;
			if (rsp_valid_i && rsp_func_i == mbos_pkg::FC_READ_EXC)
			begin
				dest_addr_o <= rsp_dest_i;
				dest_data_o <= rsp_data_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_coil_on;
		go && req_func_i == mbos_pkg::FC_WRITE_COIL &&
		req_addr_i <= mbos_pkg::COIL_ADDR_MAX &&
		req_value_i == mbos_pkg::COIL_ON;
	endsequence

	property p_coil_on;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		s_coil_on |=> dout_o[$past(req_addr_i[3:0])];
	endproperty
	a_coil_on: assert property (p_coil_on) // R2
		else $error("coil on write did not set output");

	property p_coil_off;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		go && req_func_i == mbos_pkg::FC_WRITE_COIL &&
		req_addr_i <= mbos_pkg::COIL_ADDR_MAX &&
		req_value_i == mbos_pkg::COIL_OFF
		|=> !dout_o[$past(req_addr_i[3:0])];
	endproperty
	a_coil_off: assert property (p_coil_off) // R3
		else $error("coil off write did not clear output");

	property p_coil_others;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		go && req_func_i == mbos_pkg::FC_WRITE_COIL
		|=> $countones(dout_o ^ $past(dout_o)) <= 1;
	endproperty
	a_coil_others: assert property (p_coil_others) // R3
		else $error("coil write changed more than one output");

	property p_preset;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		go && req_func_i == mbos_pkg::FC_PRESET_REG &&
		req_addr_i == mbos_pkg::PRESET_ADDR
		|=> dout_o == $past(req_value_i);
	endproperty
	a_preset: assert property (p_preset) // R6
		else $error("preset did not load outputs");

	property p_preset_bad;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		go && req_func_i == mbos_pkg::FC_PRESET_REG &&
		req_addr_i != mbos_pkg::PRESET_ADDR |=> $stable(dout_o);
	endproperty
	a_preset_bad: assert property (p_preset_bad) // R5
		else $error("preset at nonzero address changed outputs");

	sequence s_echo_head;
		go && req_func_i == mbos_pkg::FC_PRESET_REG &&
		req_addr_i == mbos_pkg::PRESET_ADDR;
	endsequence

	property p_echo;
		logic [7:0] v;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(s_echo_head, v = req_value_i[7:0])
		|-> ##7 tx_valid_o && tx_last_o && tx_data_o == v;
	endproperty
	a_echo: assert property (p_echo) // R4
		else $error("echo reply last byte wrong");

	property p_status;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		go && req_func_i == mbos_pkg::FC_READ_EXC
		|-> ##3 tx_valid_o && tx_data_o == mbos_pkg::FC_READ_EXC
		##1 tx_valid_o && tx_last_o && tx_data_o == $past(dout_o[7:0], 4);
	endproperty
	a_status: assert property (p_status) // R7
		else $error("exception status reply wrong");

	property p_exc;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		go && req_func_i == mbos_pkg::FC_PRESET_REG &&
		req_addr_i != mbos_pkg::PRESET_ADDR
		|-> ##3 tx_data_o == (mbos_pkg::FC_PRESET_REG | mbos_pkg::EXC_FLAG)
		##1 tx_data_o == mbos_pkg::EXC_ILLEGAL_ADDR && tx_last_o;
	endproperty
	a_exc: assert property (p_exc) // R10
		else $error("exception reply wrong");

	property p_latch;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		rsp_valid_i && rsp_func_i[7]
		|=> response_function_query_o == $past(rsp_func_i) &&
		    exception_code_query_o == $past(rsp_data_i);
	endproperty
	a_latch: assert property (p_latch) // R11
		else $error("response codes not latched");

	property p_dest;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		rsp_valid_i && rsp_func_i == mbos_pkg::FC_READ_EXC
		|=> dest_we_o && dest_data_o == $past(rsp_data_i);
	endproperty
	a_dest: assert property (p_dest) // R12
		else $error("status byte not stored");
endmodule : mbos_slave
`default_nettype wire

// [verilog/mbos_pkg.sv]
// Constants and types shared by the modbus output slave block
package mbos_pkg;
	// ----------------------------------------------------------------
	// Function codes and field values
	// ----------------------------------------------------------------
	localparam logic [7:0]  FC_WRITE_COIL    = 8'h05;
	localparam logic [7:0]  FC_PRESET_REG    = 8'h06;
	localparam logic [7:0]  FC_READ_EXC      = 8'h07;
	localparam logic [7:0]  EXC_FLAG         = 8'h80;
	localparam logic [7:0]  EXC_ILLEGAL_FUNC = 8'h01;
	localparam logic [7:0]  EXC_ILLEGAL_ADDR = 8'h02;
	localparam logic [15:0] COIL_ON          = 16'hFF00;
	localparam logic [15:0] COIL_OFF         = 16'h0000;
	localparam logic [15:0] COIL_ADDR_MAX    = 16'h000F;
	localparam logic [15:0] PRESET_ADDR      = 16'h0000;
	// ----------------------------------------------------------------
	// Reset values and sizes
	// ----------------------------------------------------------------
	localparam logic [15:0] OUT_RST          = 16'h0000;
	localparam logic [7:0]  BYTE_RST         = 8'h00;
	localparam int          REQ_BYTES        = 5;
	localparam int          EXC_BYTES        = 2;
	localparam int          STAT_BYTES       = 2;
	localparam int          BYTES_W          = 3;
	// Reply emitter states
	typedef enum logic [1:0] {MBOS_IDLE, MBOS_SEND} mbos_tx_state_t;
endpackage : mbos_pkg

// [verilog/mbos_reply_if.sv]
// Reply frame handed from the decoder to the byte emitter
`timescale 1ns/1ps
`default_nettype none
interface mbos_reply_if;
	logic       start;
	logic [7:0] frame [5];
	logic [2:0] len;
	logic       busy;
	modport src (output start, output frame, output len, input busy);
	modport dst (input start, input frame, input len, output busy);
endinterface : mbos_reply_if
`default_nettype wire

// [verilog/mbos_reply_tx.sv]
// Byte emitter that sends a reply frame one byte per cycle
`timescale 1ns/1ps
`default_nettype none
module mbos_reply_tx
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_b_i,
	mbos_reply_if.dst       rep,
	output logic            tx_valid_o,
	output logic [7:0]      tx_data_o,
	output logic            tx_last_o
);
	mbos_pkg::mbos_tx_state_t state_q;
	logic [2:0]               idx_q;
	logic [7:0]               buf_q [5];
	logic [2:0]               len_q;

	// ----------------------------------------------------------------
	// Frame capture and byte stepping
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			state_q    <= mbos_pkg::MBOS_IDLE;
			idx_q      <= '0;
			len_q      <= '0;
			tx_valid_o <= 1'b0;
			tx_data_o  <= mbos_pkg::BYTE_RST;
			tx_last_o  <= 1'b0;
			for (int i = 0; i < 5; i++)
				buf_q[i] <= mbos_pkg::BYTE_RST;
		end
		else
		begin
			unique case (state_q)
				mbos_pkg::MBOS_IDLE:
				begin
					tx_valid_o <= 1'b0;
					tx_last_o  <= 1'b0;
					if (rep.start)
					begin
						buf_q   <= rep.frame;
						len_q   <= rep.len;
						idx_q   <= '0;
						state_q <= mbos_pkg::MBOS_SEND;
					end
				end
				mbos_pkg::MBOS_SEND:
				begin
					tx_valid_o <= 1'b1;
					tx_data_o  <= buf_q[idx_q];
					tx_last_o  <= (idx_q == len_q - 3'd1);
					idx_q      <= idx_q + 3'd1;
					if (idx_q == len_q - 3'd1)
						state_q <= mbos_pkg::MBOS_IDLE;
				end
			endcase
		end
	end

	// Busy while a frame is pending or leaving
	assign rep.busy = (state_q != mbos_pkg::MBOS_IDLE) || tx_valid_o;
endmodule : mbos_reply_tx
`default_nettype wire

// [tb/mbos_master_model.sv]
// Behavioural remote master: drives requests and responses, gathers replies
`timescale 1ns/1ps
`default_nettype none
module mbos_master_model
(
	input  wire logic        core_clk_i,
	input  wire logic        req_ready_i,
	input  wire logic        tx_valid_i,
	input  wire logic [7:0]  tx_data_i,
	input  wire logic        tx_last_i,
	output logic             req_valid_o,
	output logic [7:0]       req_func_o,
	output logic [15:0]      req_addr_o,
	output logic [15:0]      req_value_o,
	output logic             rsp_valid_o,
	output logic [7:0]       rsp_func_o,
	output logic [7:0]       rsp_data_o,
	output logic [7:0]       rsp_dest_o
);
	logic [7:0] rx [$];
	logic       done;

	// Idle lines at time zero
	initial
	begin
		done = 1'b0;
		req_valid_o = 1'b0;
		req_func_o = 8'h00;
		req_addr_o = 16'h0000;
		req_value_o = 16'h0000;
		rsp_valid_o = 1'b0;
		rsp_func_o = 8'h00;
		rsp_data_o = 8'h00;
		rsp_dest_o = 8'h00;
	end

	// Hold request until taken, then scramble the released fields
	task automatic send(input logic [7:0] f, input logic [15:0] a,
		input logic [15:0] v, output bit ok);
		int n;
		n = 0;
		rx.delete();
		done = 1'b0;
		req_valid_o = 1'b1;
		req_func_o = f;
		req_addr_o = a;
		req_value_o = v;
		while (!req_ready_i && n < 40)
		begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		ok = req_ready_i;
		@(posedge core_clk_i);
		#1;
		req_valid_o = 1'b0;
		req_func_o = ~f;
		req_addr_o = ~a;
		req_value_o = ~v;
	endtask

	// exception response has the top bit of its function code set
	task automatic respond(input logic [7:0] f, input logic [7:0] d,
		input logic [7:0] dest);
		rsp_valid_o = 1'b1;
		rsp_func_o = f;
		rsp_data_o = d;
		rsp_dest_o = dest;
		@(posedge core_clk_i);
		#1;
		rsp_valid_o = 1'b0;
		rsp_func_o = ~f;
		rsp_data_o = ~d;
		rsp_dest_o = ~dest;
	endtask

	// Gather reply bytes and mark the final one
	always @(posedge core_clk_i)
	begin
		if (tx_valid_i)
		begin
			rx.push_back(tx_data_i);
			if (tx_last_i)
				done <= 1'b1;
		end
	end
endmodule // mbos_master_model
`default_nettype wire

// [tb/tb_modbus_output_slave.sv]
// Self-checking testbench for the modbus output slave
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_output_slave;
	logic        core_clk, rst_b, req_valid, req_ready, tx_valid, tx_last;
	logic [7:0]  req_func, tx_data, rsp_func, rsp_data, rsp_dest;
	logic [15:0] req_addr, req_value, dout, exp_out;
	logic        rsp_valid, dest_we;
	logic [7:0]  resp_q, exc_q, dest_addr, dest_data;
	int          fail_count, checks;

	mbos_slave dut (.core_clk_i(core_clk), .rst_b_i(rst_b),
		.req_valid_i(req_valid), .req_func_i(req_func),
		.req_addr_i(req_addr), .req_value_i(req_value),
		.req_ready_o(req_ready), .tx_valid_o(tx_valid),
		.tx_data_o(tx_data), .tx_last_o(tx_last), .dout_o(dout),
		.rsp_valid_i(rsp_valid), .rsp_func_i(rsp_func),
		.rsp_data_i(rsp_data), .rsp_dest_i(rsp_dest),
		.response_function_query_o(resp_q), .exception_code_query_o(exc_q),
		.dest_we_o(dest_we), .dest_addr_o(dest_addr),
		.dest_data_o(dest_data));

	mbos_master_model partner (.core_clk_i(core_clk), .req_ready_i(req_ready),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last),
		.req_valid_o(req_valid), .req_func_o(req_func),
		.req_addr_o(req_addr), .req_value_o(req_value),
		.rsp_valid_o(rsp_valid), .rsp_func_o(rsp_func),
		.rsp_data_o(rsp_data), .rsp_dest_o(rsp_dest));

	// 100 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic complete_run;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One request, whole reply compared, then the outputs
	task automatic xfer(input logic [7:0] f, input logic [15:0] a,
		input logic [15:0] v, input logic [7:0] e [5], input int len);
		bit ok;
		int n;
		partner.send(f, a, v, ok);
		n = 0;
		while (ok && !partner.done && n < 20)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (!ok || !partner.done)
		begin
			fail_count++;
			complete_run();
		end
		check(16'(partner.rx.size()), 16'(len));
		for (int i = 0; i < len; i++)
			check({8'h00, partner.rx[i]}, {8'h00, e[i]});
		check(dout, exp_out);
		check({15'h0000, req_ready}, 16'h0000);
	endtask

	// Coil on, top address, then off again
	task automatic sc_coil;
		exp_out = 16'h0080;
		xfer(8'h05, 16'h0007, 16'hFF00, '{8'h05, 8'h00, 8'h07, 8'hFF, 8'h00}, 5);
		exp_out = 16'h8080;
		xfer(8'h05, 16'h000F, 16'hFF00, '{8'h05, 8'h00, 8'h0F, 8'hFF, 8'h00}, 5);
		exp_out = 16'h8000;
		xfer(8'h05, 16'h0007, 16'h0000, '{8'h05, 8'h00, 8'h07, 8'h00, 8'h00}, 5);
	endtask

	// Refused coil, preset and function codes leave outputs alone
	task automatic sc_refused;
		xfer(8'h05, 16'h0010, 16'hFF00, '{8'h85, 8'h02, 8'h00, 8'h00, 8'h00}, 2);
		xfer(8'h05, 16'h0003, 16'h1234, '{8'h85, 8'h02, 8'h00, 8'h00, 8'h00}, 2);
		xfer(8'h06, 16'h0001, 16'hFFFF, '{8'h86, 8'h02, 8'h00, 8'h00, 8'h00}, 2);
		xfer(8'h03, 16'h0000, 16'h0000, '{8'h83, 8'h01, 8'h00, 8'h00, 8'h00}, 2);
		xfer(8'h0F, 16'h0000, 16'h0001, '{8'h8F, 8'h01, 8'h00, 8'h00, 8'h00}, 2);
	endtask

	// Preset patterns and status byte readback
	task automatic sc_preset_status;
		exp_out = 16'h55AA;
		xfer(8'h06, 16'h0000, 16'h55AA, '{8'h06, 8'h00, 8'h00, 8'h55, 8'hAA}, 5);
		xfer(8'h07, 16'h0000, 16'h0000, '{8'h07, 8'hAA, 8'h00, 8'h00, 8'h00}, 2);
		exp_out = 16'hFF00;
		xfer(8'h06, 16'h0000, 16'hFF00, '{8'h06, 8'h00, 8'h00, 8'hFF, 8'h00}, 5);
		xfer(8'h07, 16'h0000, 16'h0000, '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
		exp_out = 16'h0001;
		xfer(8'h06, 16'h0000, 16'h0001, '{8'h06, 8'h00, 8'h00, 8'h00, 8'h01}, 5);
		xfer(8'h07, 16'h0000, 16'h0000, '{8'h07, 8'h01, 8'h00, 8'h00, 8'h00}, 2);
	endtask

	// Response capture in the master role
	task automatic sc_master;
		partner.respond(8'h07, 8'hAA, 8'h03);
		check({8'h00, resp_q}, 16'h0007);
		check({15'h0000, dest_we}, 16'h0001);
		check({dest_addr, dest_data}, 16'h03AA);
		@(posedge core_clk);
		#1;
		check({15'h0000, dest_we}, 16'h0000);
		partner.respond(8'h85, 8'h02, 8'h04);
		check({resp_q, exc_q}, 16'h8502);
		partner.respond(8'h06, 8'h00, 8'h00);
		check({resp_q, exc_q}, 16'h0602);
	endtask

	// Main sequence
	initial
	begin
		fail_count = 0;
		checks = 0;
		exp_out = 16'h0000;
		rst_b = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		check(dout, 16'h0000);
		check({15'h0000, req_ready}, 16'h0000);
		rst_b = 1'b1;
		sc_coil();
		sc_refused();
		sc_preset_status();
		sc_master();
		complete_run();
	end
endmodule // tb_modbus_output_slave
`default_nettype wire
